// [verilog/rs_pwm.sv]
// Reset-synchronized three-phase PWM generator with AHB-Lite register slave
`timescale 1ns/10ps
module rs_pwm (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  // PWM outputs
  output logic             phase1_positive_out,
  output logic             phase1_inverse_out,
  output logic             phase2_positive_out,
  output logic             phase2_inverse_out,
  output logic             phase3_positive_out,
  output logic             phase3_inverse_out,
  output logic             cycle_sync_toggle_pin,
  // Cycle compare-match request
  output logic             cycle_irq
);

  localparam int W = rs_pwm_pkg::CNT_W;
  // Compare of counter against a register
  function automatic logic hit(input logic [W-1:0] a, input logic [W-1:0] b);
    hit = (a == b);
  endfunction

  rs_pwm_pkg::ctrl_s ctrl_reg;
  rs_pwm_pkg::bus_e  bus_reg;
  logic [W-1:0]      cycle_compare_reg;
  logic [W-1:0]      phase1_duty_compare_reg;
  logic [W-1:0]      phase2_duty_compare_reg;
  logic [W-1:0]      phase3_duty_compare_reg;
  logic [W-1:0]      cycle_buffer_reg;
  logic [W-1:0]      phase1_duty_buffer_reg;
  logic [W-1:0]      phase2_duty_buffer_reg;
  logic [W-1:0]      phase3_duty_buffer_reg;
  logic [W-1:0]      master_counter_reg;
  logic [W-1:0]      slave_counter_reg;
  logic              slave_run_reg;
  logic [1:0]        pre_reg;
  logic [2:0]        phase_reg;
  logic              sync_tog_reg;
  logic              flag_reg;
  logic              irq_reg;
  logic [5:0]        out_reg;
  logic              sync_out_reg;
  logic              wr_pend_reg;
  logic [7:0]        wr_addr_reg;
  logic [7:0]        rd_addr_reg;
  logic [31:0]       hrdata_reg;

  // Bus decode
  wire        take     = hsel & htrans[1] & hready;
  wire        take_rd  = take & ~hwrite;
  wire        take_wr  = take & hwrite;
  wire [7:0]  addr8    = haddr[7:0];
  wire        wr_ctrl  = wr_pend_reg & (wr_addr_reg == rs_pwm_pkg::CTRL_OFF);
  wire        wr_stat  = wr_pend_reg & (wr_addr_reg == rs_pwm_pkg::STATUS_OFF);
  wire        wr_cyc   = wr_pend_reg & (wr_addr_reg == rs_pwm_pkg::CYCLE_OFF);
  wire        wr_d1    = wr_pend_reg & (wr_addr_reg == rs_pwm_pkg::DUTY1_OFF);
  wire        wr_d2    = wr_pend_reg & (wr_addr_reg == rs_pwm_pkg::DUTY2_OFF);
  wire        wr_d3    = wr_pend_reg & (wr_addr_reg == rs_pwm_pkg::DUTY3_OFF);
  wire        wr_cb    = wr_pend_reg & (wr_addr_reg == rs_pwm_pkg::CYCLE_BUF_OFF);
  wire        wr_b1    = wr_pend_reg & (wr_addr_reg == rs_pwm_pkg::DUTY1_BUF_OFF);
  wire        wr_b2    = wr_pend_reg & (wr_addr_reg == rs_pwm_pkg::DUTY2_BUF_OFF);
  wire        wr_b3    = wr_pend_reg & (wr_addr_reg == rs_pwm_pkg::DUTY3_BUF_OFF);
  wire        wr_mcnt  = wr_pend_reg & (wr_addr_reg == rs_pwm_pkg::MCNT_OFF);
  wire        wr_scnt  = wr_pend_reg & (wr_addr_reg == rs_pwm_pkg::SCNT_OFF);
  wire        wr_sctl  = wr_pend_reg & (wr_addr_reg == rs_pwm_pkg::SCTRL_OFF);
  wire [W-1:0] wd16    = hwdata[W-1:0];

  // Count tick and cycle match
  wire        tick     = ctrl_reg.run & ctrl_reg.rs_mode & (pre_reg == rs_pwm_pkg::PRE_LAST);
  wire        cyc_hit  = tick & hit(master_counter_reg, cycle_compare_reg);
  wire        load_a   = cyc_hit & ctrl_reg.buf_a;
  wire        load_b   = cyc_hit & ctrl_reg.buf_b;

  // Duty matches ignored on the clearing tick so a high duty only toggles at cycle end
  wire [2:0]  duty_hit;
  assign duty_hit[0] = tick & ~cyc_hit & hit(master_counter_reg, phase1_duty_compare_reg);
  assign duty_hit[1] = tick & ~cyc_hit & hit(master_counter_reg, phase2_duty_compare_reg);
  assign duty_hit[2] = tick & ~cyc_hit & hit(master_counter_reg, phase3_duty_compare_reg);
  wire [2:0]  phase_next = phase_reg ^ (duty_hit | {3{cyc_hit}});

  // Level selection: positive active-high follows phase, inverse active-high is its complement
  wire [2:0]  pos_next = ctrl_reg.pos_level ? phase_next : ~phase_next;
  wire [2:0]  inv_next = ctrl_reg.inv_level ? ~phase_next : phase_next;
  wire        sync_tog_next = sync_tog_reg ^ cyc_hit;
  wire        sync_next = ctrl_reg.toggle_en ? sync_tog_next : ctrl_reg.port_level;

  // Slave counter takes the master's settings in this mode
  wire        slave_go = ctrl_reg.rs_mode ? tick
                       : (slave_run_reg & (pre_reg == rs_pwm_pkg::PRE_LAST));
  wire        slave_clr = ctrl_reg.rs_mode & cyc_hit;
  // Read mux, one wait state so a just-written value is seen
  logic [31:0] rd_mux;
  always_comb
  begin
    case (rd_addr_reg)
      rs_pwm_pkg::CTRL_OFF:      rd_mux = {24'h00_0000, ctrl_reg};
      rs_pwm_pkg::STATUS_OFF:    rd_mux = {31'h0000_0000, flag_reg};
      rs_pwm_pkg::CYCLE_OFF:     rd_mux = {16'h0000, cycle_compare_reg};
      rs_pwm_pkg::DUTY1_OFF:     rd_mux = {16'h0000, phase1_duty_compare_reg};
      rs_pwm_pkg::DUTY2_OFF:     rd_mux = {16'h0000, phase2_duty_compare_reg};
      rs_pwm_pkg::DUTY3_OFF:     rd_mux = {16'h0000, phase3_duty_compare_reg};
      rs_pwm_pkg::CYCLE_BUF_OFF: rd_mux = {16'h0000, cycle_buffer_reg};
      rs_pwm_pkg::DUTY1_BUF_OFF: rd_mux = {16'h0000, phase1_duty_buffer_reg};
      rs_pwm_pkg::DUTY2_BUF_OFF: rd_mux = {16'h0000, phase2_duty_buffer_reg};
      rs_pwm_pkg::DUTY3_BUF_OFF: rd_mux = {16'h0000, phase3_duty_buffer_reg};
      rs_pwm_pkg::MCNT_OFF:      rd_mux = {16'h0000, master_counter_reg};
      rs_pwm_pkg::SCNT_OFF:      rd_mux = {16'h0000, slave_counter_reg};
      rs_pwm_pkg::SCTRL_OFF:     rd_mux = {31'h0000_0000, slave_run_reg};
      default:                   rd_mux = 32'h0000_0000;
    endcase
  end

  // Bus phase tracking
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_reg     <= rs_pwm_pkg::BUS_IDLE;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rd_addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= take_wr;
      if (take)
      begin
        wr_addr_reg <= addr8;
        rd_addr_reg <= addr8;
      end
      case (bus_reg)
        rs_pwm_pkg::BUS_RWAIT: bus_reg <= rs_pwm_pkg::BUS_RDONE;
        rs_pwm_pkg::BUS_IDLE,
        rs_pwm_pkg::BUS_RDONE: bus_reg <= take_rd ? rs_pwm_pkg::BUS_RWAIT : rs_pwm_pkg::BUS_IDLE;
        default:               bus_reg <= rs_pwm_pkg::BUS_IDLE;
      endcase
    end
  end

  // Read data captured in the wait cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_reg <= 32'h0000_0000;
    else if (bus_reg == rs_pwm_pkg::BUS_RWAIT)
      hrdata_reg <= rd_mux;
  end

  // Control and slave control registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg      <= rs_pwm_pkg::CTRL_RESET;
      slave_run_reg <= 1'b0;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_reg <= hwdata[rs_pwm_pkg::CTRL_W-1:0];
      if (wr_sctl)
        slave_run_reg <= hwdata[0];
    end
  end

  // Prescaler: one count tick every fourth clock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pre_reg <= 2'h0;
    else
      pre_reg <= pre_reg + 2'h1;
  end

  // Master counter; a software write wins over counting
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      master_counter_reg <= rs_pwm_pkg::CNT_RESET;
    else if (wr_mcnt)
      master_counter_reg <= wd16;
    else if (cyc_hit)
      master_counter_reg <= rs_pwm_pkg::CNT_RESET;
    else if (tick)
      master_counter_reg <= master_counter_reg + 16'h0001;
  end

  // Slave counter
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      slave_counter_reg <= rs_pwm_pkg::CNT_RESET;
    else if (wr_scnt)
      slave_counter_reg <= wd16;
    else if (slave_clr)
      slave_counter_reg <= rs_pwm_pkg::CNT_RESET;
    else if (slave_go)
      slave_counter_reg <= slave_counter_reg + 16'h0001;
  end

  // Compare registers; buffer transfer at cycle match beats a software write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cycle_compare_reg       <= rs_pwm_pkg::CYCLE_RESET;
      phase1_duty_compare_reg <= rs_pwm_pkg::DUTY_RESET;
      phase2_duty_compare_reg <= rs_pwm_pkg::DUTY_RESET;
      phase3_duty_compare_reg <= rs_pwm_pkg::DUTY_RESET;
    end
    else
    begin
      if (load_a)
        cycle_compare_reg <= cycle_buffer_reg;
      else if (wr_cyc)
        cycle_compare_reg <= wd16;
      if (load_a)
        phase2_duty_compare_reg <= phase2_duty_buffer_reg;
      else if (wr_d2)
        phase2_duty_compare_reg <= wd16;
      if (load_b)
        phase1_duty_compare_reg <= phase1_duty_buffer_reg;
      else if (wr_d1)
        phase1_duty_compare_reg <= wd16;
      if (load_b)
        phase3_duty_compare_reg <= phase3_duty_buffer_reg;
      else if (wr_d3)
        phase3_duty_compare_reg <= wd16;
    end
  end

  // Buffer registers, written by software only
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cycle_buffer_reg       <= rs_pwm_pkg::CYCLE_RESET;
      phase1_duty_buffer_reg <= rs_pwm_pkg::DUTY_RESET;
      phase2_duty_buffer_reg <= rs_pwm_pkg::DUTY_RESET;
      phase3_duty_buffer_reg <= rs_pwm_pkg::DUTY_RESET;
    end
    else
    begin
      if (wr_cb)
        cycle_buffer_reg <= wd16;
      if (wr_b1)
        phase1_duty_buffer_reg <= wd16;
      if (wr_b2)
        phase2_duty_buffer_reg <= wd16;
      if (wr_b3)
        phase3_duty_buffer_reg <= wd16;
    end
  end

  // Waveform state and registered pins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      phase_reg    <= 3'h0;
      sync_tog_reg <= 1'b0;
      out_reg      <= 6'h00;
      sync_out_reg <= 1'b0;
    end
    else
    begin
      phase_reg    <= phase_next;
      sync_tog_reg <= sync_tog_next;
      out_reg      <= {inv_next, pos_next};
      sync_out_reg <= sync_next;
    end
  end

  // Cycle match request pulse and sticky flag; setting wins over clearing
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_reg  <= 1'b0;
      flag_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= cyc_hit;
      if (cyc_hit)
        flag_reg <= 1'b1;
      else if (wr_stat & hwdata[rs_pwm_pkg::FLAG_BIT])
        flag_reg <= 1'b0;
    end
  end

  // Output wiring
  assign hreadyout             = (bus_reg != rs_pwm_pkg::BUS_RWAIT);
  assign hrdata                = hrdata_reg;
  assign hresp                 = 1'b0;
  assign phase1_positive_out   = out_reg[0];
  assign phase2_positive_out   = out_reg[1];
  assign phase3_positive_out   = out_reg[2];
  assign phase1_inverse_out    = out_reg[3];
  assign phase2_inverse_out    = out_reg[4];
  assign phase3_inverse_out    = out_reg[5];
  assign cycle_sync_toggle_pin = sync_out_reg;
  assign cycle_irq             = irq_reg;
endmodule // rs_pwm

// [include/rs_pwm_pkg.sv]
// Package: register map, field layout and timing constants of the PWM block
package rs_pwm_pkg;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF       = 8'h00;
  localparam logic [7:0] STATUS_OFF     = 8'h04;
  localparam logic [7:0] CYCLE_OFF      = 8'h08;
  localparam logic [7:0] DUTY1_OFF      = 8'h0C;
  localparam logic [7:0] DUTY2_OFF      = 8'h10;
  localparam logic [7:0] DUTY3_OFF      = 8'h14;
  localparam logic [7:0] CYCLE_BUF_OFF  = 8'h18;
  localparam logic [7:0] DUTY1_BUF_OFF  = 8'h1C;
  localparam logic [7:0] DUTY2_BUF_OFF  = 8'h20;
  localparam logic [7:0] DUTY3_BUF_OFF  = 8'h24;
  localparam logic [7:0] MCNT_OFF       = 8'h28;
  localparam logic [7:0] SCNT_OFF       = 8'h2C;
  localparam logic [7:0] SCTRL_OFF      = 8'h30;

  // Control register field positions, plus the status register flag bit
  localparam int RUN_BIT     = 0;
  localparam int BFA_BIT     = 1;
  localparam int BFB_BIT     = 2;
  localparam int POSITIVE_LEVEL_SELECT_BIT    = 3;
  localparam int INVERSE_LEVEL_SELECT_BIT    = 4;
  localparam int TOG_EN_BIT  = 5;
  localparam int PORT_LV_BIT = 6;
  localparam int RSMODE_BIT  = 7;
  localparam int CTRL_W      = 8;
  localparam int FLAG_BIT    = 0;

  // Widths and reset values
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_RESET   = 16'h0000;
  localparam logic [CNT_W-1:0] CYCLE_RESET = 16'hFFFF;
  localparam logic [CNT_W-1:0] DUTY_RESET  = 16'h0000;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;

  // Count tick: peripheral clock divided by four
  localparam int PRESCALE = 4;
  localparam logic [1:0] PRE_LAST = 2'(PRESCALE - 1);

  // Control fields carried together
  typedef struct packed {
    logic rs_mode;
    logic port_level;
    logic toggle_en;
    logic inv_level;
    logic pos_level;
    logic buf_b;
    logic buf_a;
    logic run;
  } ctrl_s;

  // Bus-side phase tracker
  typedef enum logic [2:0] {
    BUS_IDLE  = 3'b001,
    BUS_RWAIT = 3'b010,
    BUS_RDONE = 3'b100
  } bus_e;

endpackage

// [verif/rs_pwm_monitor.sv]
// Checker of bus handshake and carrier-cycle event relations at the block's ports
`timescale 1ns/10ps
module rs_pwm_monitor (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus side
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Drive side
  input wire logic        phase1_positive_out,
  input wire logic        phase1_inverse_out,
  input wire logic        phase2_positive_out,
  input wire logic        phase2_inverse_out,
  input wire logic        phase3_positive_out,
  input wire logic        phase3_inverse_out,
  input wire logic        cycle_sync_toggle_pin,
  input wire logic        cycle_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // Accepted address phases
  wire logic rd_req = hsel & htrans[1] & hready & ~hwrite;
  wire logic wr_req = hsel & htrans[1] & hready & hwrite;
  logic      wr_seen;

  // Delayed write marker; a control write may legally move the sync pin
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wr_seen <= 1'b0;
    else
      wr_seen <= wr_req;
  end

  a_resp_always_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_read_one_wait: assert property (rd_req |=> !hreadyout ##1 hreadyout)
    else $error("read wait state not exactly one cycle");
  a_write_no_wait: assert property (wr_req |=> hreadyout)
    else $error("write data phase stalled");
  a_rdata_only_read: assert property ($changed(hrdata) |-> $past(rd_req, 2))
    else $error("read data moved without a read");
  a_irq_spacing: assert property (cycle_irq |=> !cycle_irq [*3])
    else $error("cycle request closer than one count tick");
  a_clear_toggles_pos: assert property (cycle_irq |-> ##[0:1]
    ($changed(phase1_positive_out) && $changed(phase2_positive_out)
     && $changed(phase3_positive_out)))
    else $error("positive set missed the clear toggle");
  a_clear_toggles_inv: assert property (cycle_irq |-> ##[0:1]
    ($changed(phase1_inverse_out) && $changed(phase2_inverse_out)
     && $changed(phase3_inverse_out)))
    else $error("inverse set missed the clear toggle");
  a_sync_cause: assert property ($changed(cycle_sync_toggle_pin) |->
    cycle_irq || $past(cycle_irq) || $past(wr_seen) || $past(wr_seen, 2))
    else $error("sync pin moved without cycle end or write");

  // Main scenarios reached
  c_read: cover property (rd_req);
  c_irq: cover property (cycle_irq);
  c_sync: cover property ($changed(cycle_sync_toggle_pin));
endmodule // rs_pwm_monitor

bind rs_pwm rs_pwm_monitor u_monitor (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .phase1_positive_out(phase1_positive_out), .phase1_inverse_out(phase1_inverse_out),
  .phase2_positive_out(phase2_positive_out), .phase2_inverse_out(phase2_inverse_out),
  .phase3_positive_out(phase3_positive_out), .phase3_inverse_out(phase3_inverse_out),
  .cycle_sync_toggle_pin(cycle_sync_toggle_pin), .cycle_irq(cycle_irq)
);

// [verif/rs_pwm_gate_model.sv]
// Gate-driver model: counts level changes per drive line, flags shoot-through
`timescale 1ns/10ps
module rs_pwm_gate_model (
  // Clock and window control
  input  wire logic            hclk,
  input  wire logic            clr,
  // Drive lines: request, sync, then positive/inverse per phase
  input  wire logic [7:0]      lines,
  // Observations
  output logic      [7:0][7:0] edges,
  output logic                 shoot
);
  logic [7:0] last;

  // Both legs of one phase high would short the inverter bridge
  always_ff @(posedge hclk)
  begin
    last  <= lines;
    shoot <= clr ? 1'b0 : shoot | (lines[0] & lines[1]) | (lines[2] & lines[3])
             | (lines[4] & lines[5]);
    for (int i = 0; i < 8; i++)
      edges[i] <= clr ? 8'h00 : edges[i] + 8'(lines[i] != last[i]);
  end
endmodule // rs_pwm_gate_model

// [verif/test_three_phase_reset_sync_pwm.sv]
// Self-checking bench of the reset-synchronized three-phase PWM block
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH %0t %h %h", $time, (a), (e)); end end
module test_three_phase_reset_sync_pwm;
  logic                 hclk    = 1'b0;
  logic                 hresetn = 1'b0;
  logic [7:0]           addr_lo = 8'h00;
  logic [1:0]           htrans  = 2'h0;
  logic                 hwrite  = 1'b0;
  logic [31:0]          hwdata  = 32'h0;
  logic                 clr     = 1'b0;
  logic [31:0]          rd;
  logic [31:0]          held;
  wire logic            hreadyout;
  wire logic            hresp;
  wire logic            cycle_irq;
  wire logic            sync_pin;
  wire logic [31:0]     hrdata;
  wire logic [5:0]      gate;
  wire logic [7:0][7:0] edges;
  wire logic            shoot;
  int                   errors = 0;
  int                   comparisons = 0;

  // Bus clock, 100 ns period
  always #50 hclk = ~hclk;

  rs_pwm u_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr({24'h0, addr_lo}), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .phase1_positive_out(gate[0]), .phase1_inverse_out(gate[1]),
    .phase2_positive_out(gate[2]), .phase2_inverse_out(gate[3]),
    .phase3_positive_out(gate[4]), .phase3_inverse_out(gate[5]),
    .cycle_sync_toggle_pin(sync_pin), .cycle_irq(cycle_irq)
  );

  rs_pwm_gate_model u_gates (
    .hclk(hclk), .clr(clr), .lines({cycle_irq, sync_pin, gate}), .edges(edges), .shoot(shoot)
  );

  // One single transfer; each phase held until ready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    htrans  <= 2'h2;
    hwrite  <= w;
    addr_lo <= a;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    htrans  <= 2'h0;
    hwdata  <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++n < 50);
    rd = hrdata;
    if (n >= 50)
      errors++;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    do @(posedge hclk); while (cycle_irq !== 1'b1 && ++n < 40000);
    // A request that never comes is a failure, not a silent pass
    if (n >= 40000)
      errors++;
  endtask

  // Window of n clocks; any whole number of periods gives fixed counts
  task automatic win(input int n);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    repeat (n + 1) @(posedge hclk);
  endtask

  task automatic conclude;
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rchk(rs_pwm_pkg::MCNT_OFF, 32'h0);
    rchk(rs_pwm_pkg::SCNT_OFF, 32'h0);
    rchk(rs_pwm_pkg::CYCLE_OFF, 32'hFFFF);
    rchk(8'h3C, 32'h0);
    bus(1'b1, rs_pwm_pkg::CYCLE_OFF, 32'h3);
    bus(1'b1, rs_pwm_pkg::DUTY1_OFF, 32'h1);
    bus(1'b1, rs_pwm_pkg::DUTY2_OFF, 32'h0);
    bus(1'b1, rs_pwm_pkg::DUTY3_OFF, 32'h5);
    bus(1'b1, rs_pwm_pkg::CYCLE_BUF_OFF, 32'h7);
    bus(1'b1, rs_pwm_pkg::DUTY1_BUF_OFF, 32'h2);
    bus(1'b1, rs_pwm_pkg::DUTY2_BUF_OFF, 32'h9);
    bus(1'b1, rs_pwm_pkg::DUTY3_BUF_OFF, 32'h0);
    // Run with both sets active high and sync toggling, buffers still off
    bus(1'b1, rs_pwm_pkg::CTRL_OFF, 32'hB9);
    wait_irq();
    win(32);
    `CHK(edges, 64'h0402020204040404)
    `CHK(shoot, 1'b0)
    `CHK(gate[1], ~gate[0])
    bus(1'b0, rs_pwm_pkg::MCNT_OFF, 32'h0);
    `CHK(rd[31:2], 30'h0)
    bus(1'b0, rs_pwm_pkg::SCNT_OFF, 32'h0);
    `CHK(rd[31:2], 30'h0)
    rchk(rs_pwm_pkg::CYCLE_OFF, 32'h3);
    // Buffers on: all values land together at the next cycle end
    bus(1'b1, rs_pwm_pkg::CTRL_OFF, 32'hBF);
    repeat (2) wait_irq();
    rchk(rs_pwm_pkg::CYCLE_OFF, 32'h7);
    rchk(rs_pwm_pkg::DUTY1_OFF, 32'h2);
    rchk(rs_pwm_pkg::DUTY2_OFF, 32'h9);
    rchk(rs_pwm_pkg::DUTY3_OFF, 32'h0);
    win(64);
    `CHK(edges, 64'h0402040402020404)
    rchk(rs_pwm_pkg::STATUS_OFF, 32'h1);
    // Stopped counter must hold its value
    bus(1'b1, rs_pwm_pkg::CTRL_OFF, 32'hBE);
    bus(1'b0, rs_pwm_pkg::MCNT_OFF, 32'h0);
    held = rd;
    rchk(rs_pwm_pkg::MCNT_OFF, held);
    // Slave's own run bit is ignored while the master mode is selected
    bus(1'b1, rs_pwm_pkg::SCTRL_OFF, 32'h1);
    bus(1'b0, rs_pwm_pkg::SCNT_OFF, 32'h0);
    held = rd;
    rchk(rs_pwm_pkg::SCNT_OFF, held);
    // Cycle flag clears by writing one while no match can occur
    bus(1'b1, rs_pwm_pkg::STATUS_OFF, 32'h1);
    rchk(rs_pwm_pkg::STATUS_OFF, 32'h0);
    // Full-size carrier at half duty, as software would run it
    bus(1'b1, rs_pwm_pkg::CYCLE_BUF_OFF, 32'hF9F);
    bus(1'b1, rs_pwm_pkg::DUTY1_BUF_OFF, 32'h7CF);
    bus(1'b1, rs_pwm_pkg::DUTY2_BUF_OFF, 32'h7CF);
    bus(1'b1, rs_pwm_pkg::DUTY3_BUF_OFF, 32'h7CF);
    bus(1'b1, rs_pwm_pkg::CTRL_OFF, 32'hBF);
    repeat (3) wait_irq();
    win(16000);
    `CHK(edges, 64'h0201020202020202)
    // Sync pin as a plain port level
    bus(1'b1, rs_pwm_pkg::CTRL_OFF, 32'h40);
    rchk(rs_pwm_pkg::CTRL_OFF, 32'h40);
    `CHK(sync_pin, 1'b1)
    // Positive set active high, inverse set active low: both legs follow the phase
    bus(1'b1, rs_pwm_pkg::CTRL_OFF, 32'h48);
    rchk(rs_pwm_pkg::CTRL_OFF, 32'h48);
    `CHK(gate[1], gate[0])
    conclude();
  end

  // Guard against a hang; the full run needs about 50000 clocks
  initial
  begin
    #8000000;
    errors++;
    conclude();
  end
endmodule // test_three_phase_reset_sync_pwm
